// file: src/system_memory_select_decode.v
// Purpose: chip selects and page/bank address lines for the system memory
// Assumes: all pin inputs asynchronous to mclk; three-stage synchronisers
// Notes:   outputs registered; one select active at most per memory cycle
// How it works
// - upper decoder uses a13/a14, gated by gate one
// - lower decoder uses port lines zero/four, gate two
// - chip enables combine decode, port lines, cpu strobes
// - page lines drive boot rom top address bits
// - code rom bank chosen by bank-select decode output
// - mass-store rom a14 tied high
// - 32k application ram has its own enable
// - 32k capture ram has its own enable
// - a15 picks upper or lower decoder
// - gates assert only on memory cycles
// - low address byte latched on strobe rise
`timescale 1ns/1ps
`include "memsel_defs.vh"
module system_memory_select_decode (
  input  wire       mclk,
  input  wire       rst,
  input  wire [7:0] muxed_addr_data_bus,
  input  wire [7:0] addr_high,
  input  wire       ale,
  input  wire       io_mem_n,
  input  wire       rd_n,
  input  wire       wr_n,
  input  wire       port_line_zero,
  input  wire       page_select_low,
  input  wire       page_select_high,
  input  wire       port_line_four,
  output reg  [7:0] addr_low,
  output reg  [1:0] page_rom_addr_hi,
  output reg        code_rom_bank,
  output reg        mass_rom_a14,
  output reg        page_rom_ce_n,
  output reg        code_rom_ce_n,
  output reg        mass_rom_ce_n,
  output reg        app_ram_ce_n,
  output reg        cap_ram_ce_n,
  output reg        mem_oe_n,
  output reg        mem_we_n
);
  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  // three stages per pin; a change counts once stages two and three agree
  localparam NIN = `SYNC_W;

  wire [NIN-1:0] raw;
  wire [NIN-1:0] agree;
  wire [NIN-1:0] nxt_stable;
  reg  [NIN-1:0] s1_ff;
  reg  [NIN-1:0] s2_ff;
  reg  [NIN-1:0] s3_ff;
  reg  [NIN-1:0] stable_ff;

  assign raw = {muxed_addr_data_bus,
                addr_high,
                ale,
                io_mem_n,
                rd_n,
                wr_n,
                port_line_zero,
                page_select_low,
                page_select_high,
                port_line_four};

  assign agree      = ~(s2_ff ^ s3_ff);
  assign nxt_stable = (agree & s3_ff) | (~agree & stable_ff);

  // idle levels at reset, so no false strobe or cycle follows it
  always @(posedge mclk) begin
    if (rst) begin
      s1_ff     <= `SYNC_IDLE;
      s2_ff     <= `SYNC_IDLE;
      s3_ff     <= `SYNC_IDLE;
      stable_ff <= `SYNC_IDLE;
    end else begin
      s1_ff     <= raw;
      s2_ff     <= s1_ff;
      s3_ff     <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  // ****************************************************************
  // synchronised pin fields
  // ****************************************************************
  wire [7:0] bus_s;
  wire [7:0] ahi_s;
  wire       ale_s;
  wire       iom_s;
  wire       rd_s;
  wire       wr_s;
  wire       pl0_s;
  wire       psl_s;
  wire       psh_s;
  wire       pl4_s;

  assign bus_s = stable_ff[23:16];
  assign ahi_s = stable_ff[15:8];
  assign ale_s = stable_ff[7];
  assign iom_s = stable_ff[6];
  assign rd_s  = stable_ff[5];
  assign wr_s  = stable_ff[4];
  assign pl0_s = stable_ff[3];
  assign psl_s = stable_ff[2];
  assign psh_s = stable_ff[1];
  assign pl4_s = stable_ff[0];

  // ****************************************************************
  // address latch
  // ****************************************************************
  wire [7:0] addr_low_q;
  addr_low_latch u_latch (
    .mclk        (mclk),
    .rst         (rst),
    .ale_sync    (ale_s),
    .bus_sync    (bus_s),
    .addr_low_ff (addr_low_q)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  function [3:0] dec2to4;
    input       gate_n;
    input [1:0] sel;
    begin
      dec2to4 = 4'hf;
      if (!gate_n) begin
        dec2to4 = ~(4'h1 << sel);
      end
    end
  endfunction

  // enable term for one decoder output during a strobe
  function sel_hit;
    input       strobe;
    input [3:0] en_n;
    input [1:0] code;
    begin
      sel_hit = strobe & ~en_n[code];
    end
  endfunction

  reg       decoder_one_gate_n;
  reg       decoder_two_gate_n;
  reg [3:0] upper_en_n;
  reg [3:0] lower_en_n;
  reg       code_bank_select_n;
  reg       cyc;
  reg       mem_cyc;
  reg       mem_rd;
  reg       mem_wr;
  reg       page_hit;
  reg       code_hit;
  reg       mass_hit;
  reg       app_hit;
  reg       cap_hit;

  always @* begin
    mem_cyc = ~iom_s;
    cyc = ~rd_s | ~wr_s;
    mem_rd = mem_cyc & ~rd_s;
    mem_wr = mem_cyc & ~wr_s;
    decoder_one_gate_n = ~(mem_cyc & ahi_s[`ADDR_HI_BIT-8]);
    decoder_two_gate_n = ~(mem_cyc & ~ahi_s[`ADDR_HI_BIT-8]);
    upper_en_n = dec2to4(decoder_one_gate_n,
                         {ahi_s[`DEC1_SEL_HI-8], ahi_s[`DEC1_SEL_LO-8]});
    lower_en_n = dec2to4(decoder_two_gate_n, {pl4_s, pl0_s});
    code_bank_select_n = lower_en_n[`CODE_BANK_CODE];
    // upper half: rom regions; lower half: rams and the code rom bank line
    page_hit = sel_hit(cyc, upper_en_n, `PAGE_ROM_CODE);
    code_hit = sel_hit(cyc, upper_en_n, `CODE_ROM_CODE_A) |
               sel_hit(cyc, upper_en_n, `CODE_ROM_CODE_B);
    mass_hit = sel_hit(cyc, upper_en_n, `MASS_ROM_CODE);
    app_hit  = sel_hit(cyc, lower_en_n, `APP_RAM_CODE);
    cap_hit  = sel_hit(cyc, lower_en_n, `CAP_RAM_CODE);
  end

  // ****************************************************************
  // output registers
  // ****************************************************************
  // address and page lines
  always @(posedge mclk) begin
    if (rst) begin
      addr_low         <= 8'h00;
      page_rom_addr_hi <= 2'h0;
      code_rom_bank    <= 1'b0;
      mass_rom_a14     <= `MASS_A14_LEVEL;
    end else begin
      addr_low         <= addr_low_q;
      page_rom_addr_hi <= {psh_s, psl_s};
      code_rom_bank    <= ~code_bank_select_n;
      mass_rom_a14     <= `MASS_A14_LEVEL;
    end
  end

  // chip enables, active low
  always @(posedge mclk) begin
    if (rst) begin
      page_rom_ce_n <= 1'b1;
      code_rom_ce_n <= 1'b1;
      mass_rom_ce_n <= 1'b1;
      app_ram_ce_n  <= 1'b1;
      cap_ram_ce_n  <= 1'b1;
    end else begin
      page_rom_ce_n <= ~page_hit;
      code_rom_ce_n <= ~code_hit;
      mass_rom_ce_n <= ~mass_hit;
      app_ram_ce_n  <= ~app_hit;
      cap_ram_ce_n  <= ~cap_hit;
    end
  end

  // memory read and write strobes
  always @(posedge mclk) begin
    if (rst) begin
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
    end else begin
      mem_oe_n <= ~mem_rd;
      mem_we_n <= ~mem_wr;
    end
  end
endmodule

// file: src/memsel_defs.vh
// Purpose: constants for the system memory select decode block
// Assumes: 20 MHz mclk
// Notes:   offsets and codes used by the decode module; the latch module uses none
`ifndef MEMSEL_DEFS_VH
`define MEMSEL_DEFS_VH
`define ADDR_HI_BIT      15
`define DEC1_SEL_HI      14
`define DEC1_SEL_LO      13
`define PAGE_W           2
`define CODE_BANK_CODE   2'h2
`define APP_RAM_CODE     2'h1
`define CAP_RAM_CODE     2'h2
`define MASS_ROM_CODE    2'h3
`define PAGE_ROM_CODE    2'h0
`define MASS_A14_LEVEL   1'b1
`define CODE_ROM_CODE_A  2'h1
`define CODE_ROM_CODE_B  2'h2
`define SYNC_W           24
`define SYNC_IDLE        24'h000070
`endif

// file: src/addr_low_latch.v
// Purpose: capture low address byte from the muxed bus on the latch strobe rise
// Assumes: strobe already synchronised to mclk
// Notes:   holds the byte until the next strobe rise
`timescale 1ns/1ps
module addr_low_latch (
  input  wire       mclk,
  input  wire       rst,
  input  wire       ale_sync,
  input  wire [7:0] bus_sync,
  output reg  [7:0] addr_low_ff
);
  reg ale_prev_ff;

  always @(posedge mclk) begin
    if (rst) begin
      ale_prev_ff <= 1'b0;
      addr_low_ff <= 8'h00;
    end else begin
      ale_prev_ff <= ale_sync;
      if (ale_sync && !ale_prev_ff) begin
        addr_low_ff <= bus_sync;
      end
    end
  end
endmodule

// file: verification/memsel_props.sv
// Purpose: port checks for the memory select decode
// Assumes: selects follow pins after 5 cycles
// Notes:   bound to the decode top
`timescale 1ns/1ps
module memsel_props (
  input wire logic       mclk, rst, ale, io_mem_n, rd_n, wr_n, port_line_zero,
  input wire logic       port_line_four, page_select_low, page_select_high,
  input wire logic [7:0] muxed_addr_data_bus, addr_high, addr_low,
  input wire logic [1:0] page_rom_addr_hi,
  input wire logic       code_rom_bank, mass_rom_a14, page_rom_ce_n, code_rom_ce_n,
  input wire logic       mass_rom_ce_n, app_ram_ce_n, cap_ram_ce_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire logic [4:0] ce_n = {page_rom_ce_n, code_rom_ce_n, mass_rom_ce_n, app_ram_ce_n,
                           cap_ram_ce_n};
  wire logic       rdm  = !io_mem_n && !rd_n;
  wire logic [2:0] up   = addr_high[7:5];
  wire logic [2:0] lo   = {addr_high[7], port_line_four, port_line_zero};
  // a memory read held on one decode code for the full latency
  sequence rd_at(logic [2:0] s, logic [2:0] v);
    (rdm && s == v)[*6];
  endsequence
  one_enable_a: assert property ($countones(~ce_n) <= 1) else $error("two enables");
  io_quiet_a: assert property (io_mem_n[*6] |-> &ce_n) else $error("enable in io");
  idle_quiet_a: assert property ((rd_n && wr_n)[*6] |-> &ce_n) else $error("idle enable");
  page_hit_a: assert property (rd_at(up, 3'h4) |-> !page_rom_ce_n) else $error("page");
  mass_hit_a: assert property (rd_at(up, 3'h7) |-> !mass_rom_ce_n && mass_rom_a14)
    else $error("mass");
  app_hit_a: assert property (rd_at(lo, 3'h1) |-> !app_ram_ce_n) else $error("app");
  cap_bank_a: assert property (rd_at(lo, 3'h2) |-> !cap_ram_ce_n && code_rom_bank)
    else $error("cap");
  page_lines_a: assert property ($stable({page_select_high, page_select_low})[*5]
    |-> page_rom_addr_hi == {page_select_high, page_select_low}) else $error("page lines");
  low_latch_a: assert property ($rose(ale) |-> ##7 addr_low == $past(muxed_addr_data_bus, 7))
    else $error("low byte");
endmodule
bind system_memory_select_decode memsel_props memsel_props_i (.*);

// file: verification/cpu_bus_model.sv
// Purpose: system cpu bus side of the memory decode
// Assumes: drives on the falling clock edge
// Notes:   released bus shows the inverted byte
`timescale 1ns/1ps
module cpu_bus_model (
  output logic [7:0] bus, addr_high,
  output logic       ale, io_mem_n, rd_n, wr_n,
  input wire logic   mclk
);
  initial {bus, addr_high, ale, io_mem_n, rd_n, wr_n} = 20'h00007;
  task automatic run(input logic [15:0] a, input logic io, input logic wr);
    @(negedge mclk);
    {addr_high, bus, io_mem_n, rd_n, wr_n} = {a, io, 2'h3};
    repeat (6) @(negedge mclk);
    ale = 1;
    repeat (3) @(negedge mclk);
    ale = 0;
    bus = ~a[7:0];
    {rd_n, wr_n} = {wr, !wr};
    repeat (8) @(negedge mclk);
  endtask
endmodule

// file: verification/system_memory_select_decode_test.sv
// Purpose: self-checking bench for the memory decode
// Assumes: 50 ns clock, sync reset
// Notes:   random a12..a0 and page lines; a15..a13 and port lines from the loop count
`timescale 1ns/1ps
module system_memory_select_decode_test;
  logic        mclk = 0, rst = 1, pl0 = 0, pl4 = 0, psl = 0, psh = 0, bank, a14, ale, io;
  logic        rd_n, wr_n, iox, oe, we;
  logic [7:0]  bus, ah, addr_low;
  logic [1:0]  page;
  logic [4:0]  ce_n;
  logic [15:0] a;
  logic [31:0] r, seed = 32'd38359;
  int          err_total = 0, n_tests = 0;
  initial forever #25 mclk = ~mclk;
  cpu_bus_model cpu_bus_model_i (.bus(bus), .addr_high(ah), .ale(ale), .io_mem_n(io),
    .rd_n(rd_n), .wr_n(wr_n), .mclk(mclk));
  system_memory_select_decode system_memory_select_decode_i (.mclk(mclk), .rst(rst),
    .muxed_addr_data_bus(bus), .addr_high(ah), .ale(ale), .io_mem_n(io), .rd_n(rd_n),
    .wr_n(wr_n), .port_line_zero(pl0), .page_select_low(psl), .page_select_high(psh),
    .port_line_four(pl4), .addr_low(addr_low), .page_rom_addr_hi(page),
    .code_rom_bank(bank), .mass_rom_a14(a14), .page_rom_ce_n(ce_n[4]),
    .code_rom_ce_n(ce_n[3]), .mass_rom_ce_n(ce_n[2]), .app_ram_ce_n(ce_n[1]),
    .cap_ram_ce_n(ce_n[0]), .mem_oe_n(oe), .mem_we_n(we));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [4:0] exp_ce(input logic [15:0] x, input logic y);
    int k;
    k = x[15] ? 4 + x[14:13] : {pl4, pl0};
    if (y) return 5'h1f;
    case (k)
      4: return 5'h0f;
      5, 6: return 5'h17;
      7: return 5'h1b;
      1: return 5'h1d;
      2: return 5'h1e;
      default: return 5'h1f;
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge mclk);
    rst = 0;
    repeat (5) @(negedge mclk);
    for (int i = 0; i < 64; i++) begin
      r = rnd();
      a = {i[2:0], r[12:0]};
      {psh, psl} = r[17:16];
      {pl4, pl0} = i[4:3];
      iox = (i % 7 == 6);
      cpu_bus_model_i.run(a, iox, r[20]);
      check(ce_n, exp_ce(a, iox));
      check({oe, we}, {iox | r[20], iox | !r[20]});
      check(bank, !iox && !a[15] && {pl4, pl0} == 2'h2);
      check(page, {psh, psl});
      check(a14, 1'b1);
      check(addr_low, a[7:0]);
    end
    print_verdict;
  end
endmodule
